/* File: rtl/acr_cfg_regs.v */
// acr_cfg_regs.v: serially programmed configuration register bank of a
// dual-channel converter, with decoded drive, current, termination and
// offset-hold controls for the analog and output logic.
// assumes: host drives sen_n_i, sclk_i, sdata_i synchronous to clk_i.
//
// Contract
// - Writing one to the software reset bit returns every register to default and the bit clears itself.
// - With readback off the serial output pin is driven to a fixed level, never floated.
// - With readback on the serial output pin shifts register contents out to the host.
// - Clock output drive field decodes 00 default, 01 weaker, 11 stronger, 10 maximum.
// - Data output drive field decodes 00 default, 01 weaker, 11 stronger, 10 maximum.
// - Current boost field doubles nothing, clock only, or data and clock; code 11 unused.
// - Data termination selects none, 300, 180, 110, 150, 100, 81, 60 ohms for 000 to 111.
// - Clock termination selects none, 300, 180, 110, 150, 100 ohms for 000 to 101.
// - Offset hold set stops estimation and keeps the last offset; cleared leaves it active.
// - With readback off one serial write updates every function in that register at once; with it on only the control register is written.
`timescale 1ns/1ps
`include "acr_defs.vh"

module acr_cfg_regs (
  input wire clk_i,
  input wire rst_i,
  input wire sen_n_i,
  input wire sclk_i,
  input wire sdata_i,
  output wire serial_out_pin_o,
  output reg soft_rst_pulse_o,
  output wire readback_en_o,
  output reg [1:0] clk_drive_level_o,
  output reg [1:0] data_drive_level_o,
  output reg [4:0] diff_buffer_base_current_o,
  output reg [5:0] clk_buf_current_o,
  output reg [5:0] data_buf_current_o,
  output reg [8:0] data_term_ohm_o,
  output reg [8:0] clk_term_ohm_o,
  output wire offset_hold_o,
  output wire offset_est_active_o
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  reg [7:0] rst_rdbk_ff;
  reg [7:0] clk_drv_ff;
  reg [7:0] buf_cur_ff;
  reg [7:0] term_ff;
  reg [7:0] ofs_hold_ff;
  reg [7:0] rd_data;
  wire [7:0] addr;
  wire [7:0] wdata;
  wire addr_valid;
  wire frame_done;
  wire rdbk = rst_rdbk_ff[`ACR_BIT_RDBK];

  acr_ser_if u_ser (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sen_n_i(sen_n_i),
    .sclk_i(sclk_i),
    .sdata_i(sdata_i),
    .rd_data_i(rd_data),
    .rd_en_i(rdbk),
    .addr_o(addr),
    .wdata_o(wdata),
    .addr_valid_o(addr_valid),
    .frame_done_o(frame_done),
    .serial_out_o(serial_out_pin_o)
  );

  // in readback mode only the control register stays writable, so the
  // host can always leave readback mode
  wire wr_ok = frame_done & (~rdbk | (addr == `ACR_OFS_RST_RDBK));
  wire sw_rst = wr_ok & (addr == `ACR_OFS_RST_RDBK) & wdata[`ACR_BIT_SW_RST];

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_rdbk_ff <= `ACR_RST_VAL;
      clk_drv_ff <= `ACR_RST_VAL;
      buf_cur_ff <= `ACR_RST_VAL;
      term_ff <= `ACR_RST_VAL;
      ofs_hold_ff <= `ACR_RST_VAL;
      soft_rst_pulse_o <= 1'b0;
    end else begin
      soft_rst_pulse_o <= sw_rst;
      if (sw_rst) begin
        // reset bit is never stored, so it reads back zero
        rst_rdbk_ff <= `ACR_RST_VAL;
        clk_drv_ff <= `ACR_RST_VAL;
        buf_cur_ff <= `ACR_RST_VAL;
        term_ff <= `ACR_RST_VAL;
        ofs_hold_ff <= `ACR_RST_VAL;
      end else if (wr_ok) begin
        // whole byte taken in one cycle fixed bits masked
        case (addr)
          `ACR_OFS_RST_RDBK: rst_rdbk_ff <= wdata & `ACR_MASK_RST_RDBK;
          `ACR_OFS_CLK_DRV: clk_drv_ff <= wdata & `ACR_MASK_CLK_DRV;
          `ACR_OFS_BUF_CUR: buf_cur_ff <= wdata & `ACR_MASK_BUF_CUR;
          `ACR_OFS_TERM: term_ff <= wdata & `ACR_MASK_TERM;
          `ACR_OFS_OFS_HOLD: ofs_hold_ff <= wdata & `ACR_MASK_OFS_HOLD;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // readback mux
  // ----------------------------------------------------------------------
  always @* begin
    case (addr)
      `ACR_OFS_RST_RDBK: rd_data = rst_rdbk_ff;
      `ACR_OFS_CLK_DRV: rd_data = clk_drv_ff;
      `ACR_OFS_BUF_CUR: rd_data = buf_cur_ff;
      `ACR_OFS_TERM: rd_data = term_ff;
      `ACR_OFS_OFS_HOLD: rd_data = ofs_hold_ff;
      default: rd_data = 8'h00;
    endcase
  end

  assign readback_en_o = rdbk;
  assign offset_hold_o = ofs_hold_ff[`ACR_BIT_OFS_HOLD];
  assign offset_est_active_o = ~ofs_hold_ff[`ACR_BIT_OFS_HOLD];

  // ----------------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------------
  // drive level ordinal: 0 weaker, 1 default, 2 stronger, 3 maximum
  function [1:0] drv_level;
    input [1:0] code;
    begin
      case (code)
        2'h0: drv_level = 2'h1;
        2'h1: drv_level = 2'h0;
        2'h3: drv_level = 2'h2;
        default: drv_level = 2'h3;
      endcase
    end
  endfunction

  // termination in ohms, zero means none; unlisted codes give none
  function [8:0] term_ohm;
    input [2:0] code;
    begin
      case (code)
        3'h1: term_ohm = 9'h12C;
        3'h2: term_ohm = 9'h0B4;
        3'h3: term_ohm = 9'h06E;
        3'h4: term_ohm = 9'h096;
        3'h5: term_ohm = 9'h064;
        3'h6: term_ohm = 9'h051;
        3'h7: term_ohm = 9'h03C;
        default: term_ohm = 9'h000;
      endcase
    end
  endfunction

  always @* begin
    clk_drive_level_o = drv_level(clk_drv_ff[`ACR_CLK_DRV_HI:`ACR_CLK_DRV_LO]);
    data_drive_level_o = drv_level(buf_cur_ff[`ACR_DAT_DRV_HI:`ACR_DAT_DRV_LO]);
    // current in quarter milliamps
    case (buf_cur_ff[`ACR_CUR_HI:`ACR_CUR_LO])
      2'h0: diff_buffer_base_current_o = 5'h0E;
      2'h1: diff_buffer_base_current_o = 5'h0A;
      2'h2: diff_buffer_base_current_o = 5'h12;
      default: diff_buffer_base_current_o = 5'h07;
    endcase
    // unused boost code 11 falls back to base current
    clk_buf_current_o = {1'b0, diff_buffer_base_current_o};
    data_buf_current_o = {1'b0, diff_buffer_base_current_o};
    case (buf_cur_ff[`ACR_DBL_HI:`ACR_DBL_LO])
      2'h1: clk_buf_current_o = {diff_buffer_base_current_o, 1'b0};
      2'h2: begin
        clk_buf_current_o = {diff_buffer_base_current_o, 1'b0};
        data_buf_current_o = {diff_buffer_base_current_o, 1'b0};
      end
      default: ;
    endcase
    data_term_ohm_o = term_ohm(term_ff[`ACR_DTERM_HI:`ACR_DTERM_LO]);
    clk_term_ohm_o = term_ohm(term_ff[`ACR_CTERM_HI:`ACR_CTERM_LO]);
    if (term_ff[`ACR_CTERM_HI:`ACR_CTERM_LO] > 3'h5)
      clk_term_ohm_o = 9'h000;
  end

endmodule

/* File: rtl/acr_defs.vh */
// acr_defs.vh: offsets, field positions, reset values and frame sizes
// for the converter configuration register bank.
// assumes: included by bare name from the files under rtl/.
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ACR_OFS_RST_RDBK 8'h00
`define ACR_OFS_CLK_DRV 8'h10
`define ACR_OFS_BUF_CUR 8'h11
`define ACR_OFS_TERM 8'h12
`define ACR_OFS_OFS_HOLD 8'h13

// ----------------------------------------------------------------------
// writable bit masks, fixed-zero bits cleared
// ----------------------------------------------------------------------
`define ACR_MASK_RST_RDBK 8'h01
`define ACR_MASK_CLK_DRV 8'hC0
`define ACR_MASK_BUF_CUR 8'h3F
`define ACR_MASK_TERM 8'h3F
`define ACR_MASK_OFS_HOLD 8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ACR_BIT_RDBK 0
`define ACR_BIT_SW_RST 1
`define ACR_CLK_DRV_HI 7
`define ACR_CLK_DRV_LO 6
`define ACR_DAT_DRV_HI 1
`define ACR_DAT_DRV_LO 0
`define ACR_CUR_HI 3
`define ACR_CUR_LO 2
`define ACR_DBL_HI 5
`define ACR_DBL_LO 4
`define ACR_DTERM_HI 5
`define ACR_DTERM_LO 3
`define ACR_CTERM_HI 2
`define ACR_CTERM_LO 0
`define ACR_BIT_OFS_HOLD 4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ACR_RST_VAL 8'h00

// ----------------------------------------------------------------------
// serial frame: 8 address bits then 8 data bits, msb first
// ----------------------------------------------------------------------
`define ACR_ADDR_BITS 8
`define ACR_FRAME_BITS 16

`endif

/* File: rtl/acr_ser_if.v */
// acr_ser_if.v: serial frame engine, shifts in address and data and
// shifts register contents out on the readback pin.
// assumes: serial pins already synchronous to clk_i.
`timescale 1ns/1ps
`include "acr_defs.vh"

module acr_ser_if (
  input wire clk_i,
  input wire rst_i,
  input wire sen_n_i,
  input wire sclk_i,
  input wire sdata_i,
  input wire [7:0] rd_data_i,
  input wire rd_en_i,
  output wire [7:0] addr_o,
  output reg [7:0] wdata_o,
  output reg addr_valid_o,
  output reg frame_done_o,
  output wire serial_out_o
);

  reg sclk_ff;
  reg [4:0] cnt_ff;
  reg [15:0] sh_in_ff;
  reg [7:0] sh_out_ff;
  reg [7:0] addr_ff;
  wire rise = sclk_i & ~sclk_ff & ~sen_n_i;
  wire fall = ~sclk_i & sclk_ff & ~sen_n_i;
  wire [15:0] nxt_sh_in = {sh_in_ff[14:0], sdata_i};

  // address latched after bit 8; the shifter holds the data byte at frame end
  assign addr_o = addr_ff;
  // low, never floating, while readback is off
  assign serial_out_o = rd_en_i & sh_out_ff[7];

  // ----------------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_ff <= 1'b0;
      cnt_ff <= 5'h00;
      sh_in_ff <= 16'h0000;
      sh_out_ff <= 8'h00;
      addr_ff <= 8'h00;
      wdata_o <= 8'h00;
      addr_valid_o <= 1'b0;
      frame_done_o <= 1'b0;
    end else begin
      sclk_ff <= sclk_i;
      addr_valid_o <= 1'b0;
      frame_done_o <= 1'b0;
      if (sen_n_i) begin
        // frame abandoned early leaves registers untouched
        cnt_ff <= 5'h00;
      end else if (rise && cnt_ff < `ACR_FRAME_BITS) begin
        sh_in_ff <= nxt_sh_in;
        cnt_ff <= cnt_ff + 5'h01;
        if (cnt_ff == `ACR_ADDR_BITS - 1) begin
          addr_ff <= nxt_sh_in[7:0];
          addr_valid_o <= 1'b1;
        end
        if (cnt_ff == `ACR_FRAME_BITS - 1) begin
          wdata_o <= nxt_sh_in[7:0];
          frame_done_o <= 1'b1;
        end
      end
      if (addr_valid_o) begin
        // register contents loaded once the address is known
        sh_out_ff <= rd_data_i;
      end else if (fall && cnt_ff > `ACR_ADDR_BITS) begin
        sh_out_ff <= {sh_out_ff[6:0], 1'b0};
      end
    end
  end

endmodule

/* File: tb/acr_cfg_monitor.sv */
// acr_cfg_monitor.sv: port checker for acr_cfg_regs.
// assumes: bound onto acr_cfg_regs, single clock domain.
`timescale 1ns/1ps
module acr_cfg_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_out_pin_o,
  input wire logic soft_rst_pulse_o,
  input wire logic readback_en_o,
  input wire logic [1:0] clk_drive_level_o,
  input wire logic [4:0] diff_buffer_base_current_o,
  input wire logic [5:0] clk_buf_current_o,
  input wire logic [5:0] data_buf_current_o,
  input wire logic [8:0] data_term_ohm_o,
  input wire logic [8:0] clk_term_ohm_o,
  input wire logic offset_hold_o,
  input wire logic offset_est_active_o
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  hold_inverse_a: assert property (offset_est_active_o == !offset_hold_o)
    else $error("estimate flag not inverse of hold");
  out_quiet_a: assert property (!readback_en_o |-> !serial_out_pin_o)
    else $error("serial out not low with readback off");
  pulse_single_a: assert property (soft_rst_pulse_o |=> !soft_rst_pulse_o)
    else $error("soft reset pulse too long");
  swrst_default_a: assert property (soft_rst_pulse_o |-> ##1
    (!readback_en_o && !offset_hold_o && clk_drive_level_o == 2'h1 && clk_term_ohm_o == 9'h0))
    else $error("registers not default after soft reset");
  boost_pair_a: assert property (
    data_buf_current_o != {1'b0, diff_buffer_base_current_o} |->
    clk_buf_current_o == data_buf_current_o) else $error("data doubled without clock");
  clk_buf_a: assert property (clk_buf_current_o == {1'b0, diff_buffer_base_current_o} ||
    clk_buf_current_o == {diff_buffer_base_current_o, 1'b0}) else $error("clock current bad");
  base_cur_a: assert property (diff_buffer_base_current_o inside {14, 10, 18, 7})
    else $error("base current off table");
  dterm_a: assert property (data_term_ohm_o inside {0, 300, 180, 110, 150, 100, 81, 60})
    else $error("data termination off table");
  cterm_a: assert property (clk_term_ohm_o inside {0, 300, 180, 110, 150, 100})
    else $error("clock termination off table");
  cover property (soft_rst_pulse_o);
  cover property (readback_en_o && serial_out_pin_o);
  cover property (offset_hold_o);
endmodule
bind acr_cfg_regs acr_cfg_monitor i_acr_cfg_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .serial_out_pin_o(serial_out_pin_o), .soft_rst_pulse_o(soft_rst_pulse_o),
  .readback_en_o(readback_en_o), .clk_drive_level_o(clk_drive_level_o),
  .diff_buffer_base_current_o(diff_buffer_base_current_o),
  .clk_buf_current_o(clk_buf_current_o), .data_buf_current_o(data_buf_current_o),
  .data_term_ohm_o(data_term_ohm_o), .clk_term_ohm_o(clk_term_ohm_o),
  .offset_hold_o(offset_hold_o), .offset_est_active_o(offset_est_active_o));

/* File: tb/acr_host_model.sv */
// acr_host_model.sv: serial host, one 16-bit frame per call.
// assumes: clk_i is the device clock; hp sets sclk half period in cycles.
`timescale 1ns/1ps
module acr_host_model (
  input wire logic clk_i,
  input wire logic serial_out_pin_i,
  output logic sen_n_o,
  output logic sclk_o,
  output logic sdata_o
);
  initial begin
    sen_n_o = 1'b1;
    sclk_o = 1'b0;
    sdata_o = 1'b0;
  end
  // address then data, msb first; whole frame lands at once
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int hp,
                      output logic [7:0] rd);
    logic [15:0] fr;
    fr = {a, d};
    @(posedge clk_i);
    #1 sen_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdata_o = fr[i];
      repeat (hp) @(posedge clk_i);
      #1 if (i < 8) rd[i] = serial_out_pin_i;
      sclk_o = 1'b1;
      repeat (hp) @(posedge clk_i);
      #1 sclk_o = 1'b0;
    end
    repeat (hp) @(posedge clk_i);
    #1 sen_n_o = 1'b1;
    // released line must not keep the last bit
    sdata_o = ~sdata_o;
    repeat (3) @(posedge clk_i);
  endtask
endmodule

/* File: tb/testbench.sv */
// testbench.sv: self-checking bench for acr_cfg_regs.
// assumes: acr_host_model drives the serial pins.
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_i, sen_n, sclk, sdata, sout, pulse, rb_en, hold, est;
  logic [1:0] cdrv, ddrv;
  logic [4:0] base;
  logic [5:0] cbuf, dbuf;
  logic [8:0] dterm, cterm;
  logic [7:0] rd;
  int err_total = 0;
  int num_checks = 0;
  int pulses = 0;
  int lvl[4] = '{1, 0, 3, 2};
  int cur[4] = '{14, 10, 18, 7};
  int ohm[8] = '{0, 300, 180, 110, 150, 100, 81, 60};
  acr_cfg_regs i_acr_cfg_regs (.clk_i(clk_i), .rst_i(rst_i), .sen_n_i(sen_n),
    .sclk_i(sclk), .sdata_i(sdata), .serial_out_pin_o(sout), .soft_rst_pulse_o(pulse),
    .readback_en_o(rb_en), .clk_drive_level_o(cdrv), .data_drive_level_o(ddrv),
    .diff_buffer_base_current_o(base), .clk_buf_current_o(cbuf),
    .data_buf_current_o(dbuf), .data_term_ohm_o(dterm), .clk_term_ohm_o(cterm),
    .offset_hold_o(hold), .offset_est_active_o(est));
  acr_host_model i_acr_host_model (.clk_i(clk_i), .serial_out_pin_i(sout),
    .sen_n_o(sen_n), .sclk_o(sclk), .sdata_o(sdata));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (pulse === 1'b1) pulses++;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_acr_host_model.xfer(a, d, 2, rd);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    chk({sout, rb_en, hold, est}, 16'h1);
    chk({cdrv, ddrv, base}, {2'h1, 2'h1, 5'd14});
    chk({dterm, cterm}, 16'h0);
  endtask
  task automatic t_drive;
    // codes 11 and 10 are the heavy-load picks
    for (int c = 0; c < 4; c++) begin
      wr(8'h10, 8'(c << 6));
      chk(cdrv, lvl[c]);
    end
  endtask
  task automatic t_buf;
    for (int v = 0; v < 64; v++) begin
      wr(8'h11, 8'(v));
      chk(ddrv, lvl[v & 3]);
      chk(base, cur[(v >> 2) & 3]);
      chk(cbuf, cur[(v >> 2) & 3] * ((v >> 4 == 1 || v >> 4 == 2) ? 2 : 1));
      chk(dbuf, cur[(v >> 2) & 3] * ((v >> 4 == 2) ? 2 : 1));
    end
  endtask
  task automatic t_term;
    for (int c = 0; c < 8; c++) begin
      wr(8'h12, 8'((c << 3) | (7 - c)));
      chk(dterm, ohm[c]);
      chk(cterm, (7 - c > 5) ? 0 : ohm[7 - c]);
    end
  endtask
  task automatic t_hold;
    wr(8'h13, 8'h10);
    chk({hold, est}, 16'h2);
    wr(8'h13, 8'h00);
    chk({hold, est}, 16'h1);
  endtask
  task automatic t_read;
    wr(8'h10, 8'hFF);
    wr(8'h00, 8'h01);
    chk(rb_en, 16'h1);
    i_acr_host_model.xfer(8'h10, 8'h00, 3, rd);
    chk(rd, 8'hC0);
    i_acr_host_model.xfer(8'h12, 8'h00, 2, rd);
    chk(rd, 8'h38);
    i_acr_host_model.xfer(8'h05, 8'h00, 2, rd);
    chk(rd, 8'h00);
    wr(8'h13, 8'h10);
    chk(hold, 16'h0);
    wr(8'h00, 8'h00);
    chk({rb_en, sout}, 16'h0);
  endtask
  task automatic t_swrst;
    wr(8'h13, 8'h10);
    wr(8'h00, 8'h01);
    pulses = 0;
    wr(8'h00, 8'h03);
    chk(pulses, 16'h1);
    t_defaults();
  endtask
  initial begin
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_defaults();
    t_drive();
    t_buf();
    t_term();
    t_hold();
    t_read();
    t_swrst();
    finish_test();
  end
  initial begin
    #300000;
    err_total++;
    finish_test();
  end
endmodule
